// *** hw/axi_wchk_pkg.sv ***
/*
 * Checker constants: flag bits, modes, burst codes, status layout.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package axi_wchk_pkg;

	// flags kept by this block
	localparam int FLAG_COUNT = 27;

	// flag bit positions
	localparam int BIT_4K_CROSS      = 0;
	localparam int BIT_WRAP_ALIGN    = 1;
	localparam int BIT_BURST_RSVD    = 2;
	localparam int BIT_EXCL_LEN      = 3;
	localparam int BIT_CACHE         = 4;
	localparam int BIT_FIXED_LEN     = 5;
	localparam int BIT_WRAP_LEN      = 6;
	localparam int BIT_SIZE_WIDE     = 7;
	localparam int BIT_AWVALID_RST   = 8;
	localparam int BIT_ADDR_HOLD     = 9;
	localparam int BIT_BURST_HOLD    = 10;
	localparam int BIT_CACHE_HOLD    = 11;
	localparam int BIT_ID_HOLD       = 12;
	localparam int BIT_LEN_HOLD      = 13;
	localparam int BIT_LOCK_HOLD     = 14;
	localparam int BIT_PROT_HOLD     = 15;
	localparam int BIT_SIZE_HOLD     = 16;
	localparam int BIT_QOS_HOLD      = 17;
	localparam int BIT_REGION_HOLD   = 18;
	localparam int BIT_AWVALID_DROP  = 19;
	localparam int BIT_AWREADY_WAIT  = 20;
	localparam int BIT_BEAT_COUNT    = 21;
	localparam int BIT_STRB_LANE     = 22;
	localparam int BIT_WVALID_RST    = 23;
	localparam int BIT_WDATA_HOLD    = 24;
	localparam int BIT_WLAST_HOLD    = 25;
	localparam int BIT_WSTRB_HOLD    = 26;

	// protocol modes
	localparam logic [1:0] MODE_AXI4 = 2'h0;
	localparam logic [1:0] MODE_AXI3 = 2'h1;
	localparam logic [1:0] MODE_LITE = 2'h2;

	// burst type codes
	localparam logic [1:0] BURST_FIXED = 2'h0;
	localparam logic [1:0] BURST_INCR  = 2'h1;
	localparam logic [1:0] BURST_WRAP  = 2'h2;
	localparam logic [1:0] BURST_RSVD  = 2'h3;

	// length limits as awlen codes (beats minus one)
	localparam logic [7:0] LEN_MAX_FIXED = 8'h0F;
	localparam logic [7:0] LEN_WRAP_2    = 8'h01;
	localparam logic [7:0] LEN_WRAP_4    = 8'h03;
	localparam logic [7:0] LEN_WRAP_8    = 8'h07;
	localparam logic [7:0] LEN_WRAP_16   = 8'h0F;

	// 4KB page, in bytes
	localparam logic [15:0] PAGE_BYTES = 16'h1000;
	localparam int          PAGE_BITS  = 12;

	// default ready wait limit, cycles
	localparam logic [15:0] DEF_WAIT_LIMIT = 16'h0010;

	// status read port layout
	localparam int         STATUS_ADDR_W   = 10;
	localparam int         STATUS_DATA_W   = 32;
	localparam logic [9:0] STATUS_FLAG_OFS = 10'h000;
	localparam logic [1:0] RESP_OKAY       = 2'h0;

	// status read port states
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RESP = 1'b1
	} status_state_t;

endpackage

`default_nettype wire

// *** hw/axi_wchk_status.sv ***
/*
 * Read-only status port: returns the flags at one word offset, zero
 * elsewhere. Assumes flags and requester share mclk.
 */
`timescale 1ns/100ps
`default_nettype none

module axi_wchk_status #(
	parameter int FLAGS = axi_wchk_pkg::FLAG_COUNT
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic [FLAGS-1:0]  flags,
	input  wire logic [9:0]        st_araddr,
	input  wire logic              st_arvalid,
	output logic                   st_arready,
	output logic [31:0]            st_rdata,
	output logic [1:0]             st_rresp,
	output logic                   st_rvalid,
	input  wire logic              st_rready
);

	axi_wchk_pkg::status_state_t state_q;
	logic [31:0]                 rdata_q;
	logic                        addr_hit;
	logic                        take;

	// word decode; low two address bits ignored
	assign addr_hit = ({st_araddr[9:2], 2'h0} == axi_wchk_pkg::STATUS_FLAG_OFS);
	assign take     = (state_q == axi_wchk_pkg::ST_IDLE) && st_arvalid;

	// one read in flight; ready drops while the answer waits
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= axi_wchk_pkg::ST_IDLE;
			rdata_q <= 32'h0;
		end else begin
			unique case (state_q)
				axi_wchk_pkg::ST_IDLE: begin
					if (take) begin
						state_q <= axi_wchk_pkg::ST_RESP;
						rdata_q <= addr_hit ? 32'(flags) : 32'h0;
					end
				end
				axi_wchk_pkg::ST_RESP: begin
					if (st_rready)
						state_q <= axi_wchk_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign st_arready = (state_q == axi_wchk_pkg::ST_IDLE);
	assign st_rvalid  = (state_q == axi_wchk_pkg::ST_RESP);
	assign st_rdata   = rdata_q;
	assign st_rresp   = axi_wchk_pkg::RESP_OKAY;

endmodule // axi_wchk_status

`default_nettype wire

// *** hw/axi_write_checker.sv ***
/*
 * Passive write-channel checker: a sticky flag per broken rule on the
 * write address and data channels, also read on the status port.
 * Assumes aresetn and the monitored channels are synchronous to mclk.
 */
// How it works
// - full modes flag accepted INCR bursts crossing a 4KB page on bit 0.
// - full modes flag WRAP start address unaligned to size on bit 1.
// - full modes flag reserved burst code while address valid on bit 2.
// - bit 3, exclusive length over 16 beats, is never raised.
// - full modes flag non-modifiable cache with upper cache bits set, bit 4.
// - full modes flag FIXED bursts over 16 beats on bit 5.
// - full modes flag WRAP bursts not 2, 4, 8 or 16 beats on bit 6.
// - full modes flag transfer size wider than data bus on bit 7.
// - bit 8 flags address valid in first cycle after monitored reset.
// - bit 9 flags address change during a stalled address handshake.
// - full modes flag burst, cache, id, length changes while stalled.
// - bit 14, lock change while stalled, is never raised.
// - bit 15 flags protection change while address stalled.
// - full modes flag size change on 16, qos change on 17 while stalled.
// - AXI4 only flags region change while address stalled, bit 18.
// - bit 19 flags address valid dropping before ready seen.
// - bit 20 warns when address ready waits over the limit.
// - full modes flag write beat count disagreeing with length, bit 21.
// - bit 22 flags strobes on byte lanes outside the beat's bytes.
// - bit 23 flags data valid in first cycle after monitored reset.
// - bits 24 and 26 flag data or strobe change while data stalled.
// - full modes flag last marker change while data stalled, bit 25.
// - read-only status port answers every read with response zero.
`timescale 1ns/100ps
`default_nettype none

module axi_write_checker #(
	parameter logic [1:0]  PROTOCOL         = axi_wchk_pkg::MODE_AXI4,
	parameter int          ADDR_W           = 32,
	parameter int          DATA_W           = 32,
	parameter int          ID_W             = 4,
	parameter logic [15:0] READY_WAIT_LIMIT = axi_wchk_pkg::DEF_WAIT_LIMIT
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  aresetn,
	input  wire logic [ID_W-1:0]       awid,
	input  wire logic [ADDR_W-1:0]     awaddr,
	input  wire logic [7:0]            awlen,
	input  wire logic [2:0]            awsize,
	input  wire logic [1:0]            awburst,
	input  wire logic [3:0]            awcache,
	input  wire logic [2:0]            awprot,
	input  wire logic [3:0]            awqos,
	input  wire logic [3:0]            awregion,
	input  wire logic                  awvalid,
	input  wire logic                  awready,
	input  wire logic [DATA_W-1:0]     wdata,
	input  wire logic [DATA_W/8-1:0]   wstrb,
	input  wire logic                  wlast,
	input  wire logic                  wvalid,
	input  wire logic                  wready,
	input  wire logic [9:0]            st_araddr,
	input  wire logic                  st_arvalid,
	output logic                       st_arready,
	output logic [31:0]                st_rdata,
	output logic [1:0]                 st_rresp,
	output logic                       st_rvalid,
	input  wire logic                  st_rready,
	output logic [26:0]                violation_flags
);

	localparam int   LANES   = DATA_W / 8;
	localparam int   LB      = $clog2(LANES);
	localparam int   NF      = axi_wchk_pkg::FLAG_COUNT;
	localparam logic IS_FULL = (PROTOCOL != axi_wchk_pkg::MODE_LITE);
	localparam logic IS_AXI4 = (PROTOCOL == axi_wchk_pkg::MODE_AXI4);

	// last-cycle copies of both channels
	logic [ID_W-1:0]   awid_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0]        awlen_q;
	logic [2:0]        awsize_q;
	logic [1:0]        awburst_q;
	logic [3:0]        awcache_q;
	logic [2:0]        awprot_q;
	logic [3:0]        awqos_q;
	logic [3:0]        awregion_q;
	logic [DATA_W-1:0] wdata_q;
	logic [LANES-1:0]  wstrb_q;
	logic              wlast_q;
	logic              aw_stall_q;
	logic              w_stall_q;
	logic              aresetn_q;
	logic [15:0]       wait_q;
	logic [NF-1:0]     flags_q;
	logic [NF-1:0]     viol;

	// burst tracking for beat count and strobe lanes
	logic              have_addr_q;
	logic              last_seen_q;
	logic              skip_q;
	logic [8:0]        beats_q;
	logic [7:0]        len_q;
	logic [2:0]        size_q;
	logic [1:0]        burst_q;
	logic [ADDR_W-1:0] cur_addr_q;
	logic [ADDR_W-1:0] wbase_q;
	logic [15:0]       wbytes_q;

	logic              aw_hs;
	logic              w_hs;
	logic              aw_hold;
	logic              w_hold;
	logic              first_cycle;
	logic [ADDR_W-1:0] aw_szmask;
	logic [15:0]       aw_bytes;
	logic [15:0]       aw_page_end;
	logic [ADDR_W-1:0] aw_wbase;
	logic              take_now;
	logic              active;
	logic [ADDR_W-1:0] c_addr;
	logic [2:0]        c_size;
	logic [7:0]        c_len;
	logic [1:0]        c_burst;
	logic [ADDR_W-1:0] c_wbase;
	logic [15:0]       c_wbytes;
	logic              c_skip;
	logic [ADDR_W-1:0] c_szmask;
	logic [ADDR_W-1:0] c_inc;
	logic [ADDR_W-1:0] c_next;
	logic              beat_err;
	logic              late_err;
	logic [LB-1:0]     lane_lo;
	logic [LB-1:0]     lane_hi;
	logic [LANES-1:0]  lane_bad;
	logic              strb_err;

	// handshake and stall terms
	assign aw_hs       = awvalid && awready;
	assign w_hs        = wvalid && wready;
	assign aw_hold     = aw_stall_q && awvalid;
	assign w_hold      = w_stall_q && wvalid;
	assign first_cycle = aresetn && !aresetn_q;

	// address-phase burst arithmetic
	assign aw_szmask   = (ADDR_W'(1) << awsize) - ADDR_W'(1);
	assign aw_bytes    = 16'((16'(awlen) + 16'h0001) << awsize);
	assign aw_page_end = 16'(awaddr[axi_wchk_pkg::PAGE_BITS-1:0]
		& ~aw_szmask[axi_wchk_pkg::PAGE_BITS-1:0]) + aw_bytes;
	assign aw_wbase    = awaddr & ~(ADDR_W'(aw_bytes) - ADDR_W'(1));

	// address-channel content checks, full modes only
	assign viol[axi_wchk_pkg::BIT_4K_CROSS] = IS_FULL && aw_hs
		&& awburst == axi_wchk_pkg::BURST_INCR
		&& aw_page_end > axi_wchk_pkg::PAGE_BYTES;
	assign viol[axi_wchk_pkg::BIT_WRAP_ALIGN] = IS_FULL && awvalid
		&& awburst == axi_wchk_pkg::BURST_WRAP
		&& |(awaddr & aw_szmask);
	assign viol[axi_wchk_pkg::BIT_BURST_RSVD] = IS_FULL && awvalid
		&& awburst == axi_wchk_pkg::BURST_RSVD;
	assign viol[axi_wchk_pkg::BIT_EXCL_LEN] = 1'b0;
	assign viol[axi_wchk_pkg::BIT_CACHE] = IS_FULL && awvalid
		&& !awcache[1] && |awcache[3:2];
	assign viol[axi_wchk_pkg::BIT_FIXED_LEN] = IS_FULL && awvalid
		&& awburst == axi_wchk_pkg::BURST_FIXED
		&& awlen > axi_wchk_pkg::LEN_MAX_FIXED;
	assign viol[axi_wchk_pkg::BIT_WRAP_LEN] = IS_FULL && awvalid
		&& awburst == axi_wchk_pkg::BURST_WRAP
		&& awlen != axi_wchk_pkg::LEN_WRAP_2
		&& awlen != axi_wchk_pkg::LEN_WRAP_4
		&& awlen != axi_wchk_pkg::LEN_WRAP_8
		&& awlen != axi_wchk_pkg::LEN_WRAP_16;
	assign viol[axi_wchk_pkg::BIT_SIZE_WIDE] = IS_FULL && awvalid
		&& 32'(awsize) > LB;

	// first cycle after the monitored reset releases
	assign viol[axi_wchk_pkg::BIT_AWVALID_RST] = first_cycle && awvalid;
	assign viol[axi_wchk_pkg::BIT_WVALID_RST]  = first_cycle && wvalid;

	// stalled address handshake: fields must hold
	assign viol[axi_wchk_pkg::BIT_ADDR_HOLD] = aw_hold
		&& awaddr != awaddr_q;
	assign viol[axi_wchk_pkg::BIT_BURST_HOLD] = IS_FULL && aw_hold
		&& awburst != awburst_q;
	assign viol[axi_wchk_pkg::BIT_CACHE_HOLD] = IS_FULL && aw_hold
		&& awcache != awcache_q;
	assign viol[axi_wchk_pkg::BIT_ID_HOLD] = IS_FULL && aw_hold
		&& awid != awid_q;
	assign viol[axi_wchk_pkg::BIT_LEN_HOLD] = IS_FULL && aw_hold
		&& awlen != awlen_q;
	assign viol[axi_wchk_pkg::BIT_LOCK_HOLD] = 1'b0;
	assign viol[axi_wchk_pkg::BIT_PROT_HOLD] = aw_hold
		&& awprot != awprot_q;
	assign viol[axi_wchk_pkg::BIT_SIZE_HOLD] = IS_FULL && aw_hold
		&& awsize != awsize_q;
	assign viol[axi_wchk_pkg::BIT_QOS_HOLD] = IS_FULL && aw_hold
		&& awqos != awqos_q;
	// qualified by the write valid, not the read one
	assign viol[axi_wchk_pkg::BIT_REGION_HOLD] = IS_AXI4 && aw_hold
		&& awregion != awregion_q;
	assign viol[axi_wchk_pkg::BIT_AWVALID_DROP] = aw_stall_q
		&& !awvalid;
	// warns once per stall, on the first cycle past the limit
	assign viol[axi_wchk_pkg::BIT_AWREADY_WAIT] = awvalid && !awready
		&& wait_q == READY_WAIT_LIMIT;

	// stalled data handshake: beat must hold
	assign viol[axi_wchk_pkg::BIT_WDATA_HOLD] = w_hold
		&& wdata != wdata_q;
	assign viol[axi_wchk_pkg::BIT_WSTRB_HOLD] = w_hold
		&& wstrb != wstrb_q;
	assign viol[axi_wchk_pkg::BIT_WLAST_HOLD] = IS_FULL && w_hold
		&& wlast != wlast_q;

	// current burst: held one, or address taken this cycle
	assign take_now = aw_hs && !have_addr_q && !last_seen_q;
	assign active   = have_addr_q || take_now;
	assign c_addr   = have_addr_q ? cur_addr_q : awaddr;
	assign c_size   = have_addr_q ? size_q : awsize;
	assign c_len    = have_addr_q ? len_q : awlen;
	assign c_burst  = have_addr_q ? burst_q : awburst;
	assign c_wbase  = have_addr_q ? wbase_q : aw_wbase;
	assign c_wbytes = have_addr_q ? wbytes_q : aw_bytes;
	assign c_skip   = have_addr_q ? skip_q : (beats_q != 9'h000);
	assign c_szmask = (ADDR_W'(1) << c_size) - ADDR_W'(1);
	assign c_inc    = (c_addr & ~c_szmask) + (ADDR_W'(1) << c_size);

	// next beat address: fixed stays, wrap folds to its base
	assign c_next = (c_burst == axi_wchk_pkg::BURST_FIXED) ? c_addr
		: (c_burst == axi_wchk_pkg::BURST_WRAP
		&& c_inc >= c_wbase + ADDR_W'(c_wbytes)) ? c_wbase : c_inc;

	// beat count against length, on each tracked beat or on a late address
	assign beat_err = IS_FULL && w_hs && active
		&& (wlast ? beats_q != 9'(c_len) : beats_q == 9'(c_len));
	assign late_err = IS_FULL && aw_hs && last_seen_q
		&& beats_q != 9'(awlen) + 9'h001;
	assign viol[axi_wchk_pkg::BIT_BEAT_COUNT] = beat_err || late_err;

	// lite has no size: every lane is valid
	assign lane_lo = IS_FULL ? c_addr[LB-1:0] : LB'(0);
	assign lane_hi = IS_FULL ? (c_addr[LB-1:0] | c_szmask[LB-1:0])
		: {LB{1'b1}};

	// per-lane strobe legality
	genvar gi;
	generate
		for (gi = 0; gi < LANES; gi++) begin : g_lane
			assign lane_bad[gi] = wstrb[gi]
				&& (LB'(gi) < lane_lo || LB'(gi) > lane_hi);
		end
	endgenerate

	// beats that ran ahead of their address are not lane-checked
	assign strb_err = w_hs && (IS_FULL ? active && !c_skip : 1'b1)
		&& |lane_bad;
	assign viol[axi_wchk_pkg::BIT_STRB_LANE] = strb_err;

	// channel history for the hold checks, cleared by monitored reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aresetn_q  <= 1'b0;
			aw_stall_q <= 1'b0;
			w_stall_q  <= 1'b0;
		end else begin
			aresetn_q  <= aresetn;
			aw_stall_q <= aresetn && awvalid && !awready;
			w_stall_q  <= aresetn && wvalid && !wready;
		end
	end

	// field copies need no reset; only read behind a stall flag
	always_ff @(posedge mclk) begin
		awid_q     <= awid;
		awaddr_q   <= awaddr;
		awlen_q    <= awlen;
		awsize_q   <= awsize;
		awburst_q  <= awburst;
		awcache_q  <= awcache;
		awprot_q   <= awprot;
		awqos_q    <= awqos;
		awregion_q <= awregion;
		wdata_q    <= wdata;
		wstrb_q    <= wstrb;
		wlast_q    <= wlast;
	end

	// stall length counter, saturating past the limit
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			wait_q <= 16'h0000;
		else if (!aresetn || !awvalid || awready)
			wait_q <= 16'h0000;
		else if (wait_q != 16'hFFFF)
			wait_q <= wait_q + 16'h0001;
	end

	// one burst tracked at a time; later addresses pass unchecked
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			have_addr_q <= 1'b0;
			last_seen_q <= 1'b0;
			skip_q      <= 1'b0;
			beats_q     <= 9'h000;
			len_q       <= 8'h00;
			size_q      <= 3'h0;
			burst_q     <= 2'h0;
			cur_addr_q  <= '0;
			wbase_q     <= '0;
			wbytes_q    <= 16'h0000;
		end else if (!aresetn) begin
			have_addr_q <= 1'b0;
			last_seen_q <= 1'b0;
			beats_q     <= 9'h000;
		end else if (aw_hs && last_seen_q) begin
			last_seen_q <= 1'b0;
			beats_q     <= 9'h000;
		end else if (w_hs && active) begin
			have_addr_q <= !wlast;
			beats_q     <= wlast ? 9'h000 : beats_q + 9'h001;
			cur_addr_q  <= c_next;
			len_q       <= c_len;
			size_q      <= c_size;
			burst_q     <= c_burst;
			wbase_q     <= c_wbase;
			wbytes_q    <= c_wbytes;
			skip_q      <= c_skip;
		end else if (w_hs) begin
			beats_q <= beats_q + 9'h001;
			if (wlast)
				last_seen_q <= 1'b1;
		end else if (take_now) begin
			have_addr_q <= 1'b1;
			cur_addr_q  <= awaddr;
			len_q       <= awlen;
			size_q      <= awsize;
			burst_q     <= awburst;
			wbase_q     <= aw_wbase;
			wbytes_q    <= aw_bytes;
			skip_q      <= beats_q != 9'h000;
		end
	end

	// sticky flags; checks count only while the link is out of reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			flags_q <= '0;
		else if (!aresetn)
			flags_q <= '0;
		else
			flags_q <= flags_q | viol;
	end

	assign violation_flags = flags_q;

	// read-only status port
	axi_wchk_status #(
		.FLAGS (NF)
	) u_status (
		.mclk       (mclk),
		.rst        (rst),
		.flags      (flags_q),
		.st_araddr  (st_araddr),
		.st_arvalid (st_arvalid),
		.st_arready (st_arready),
		.st_rdata   (st_rdata),
		.st_rresp   (st_rresp),
		.st_rvalid  (st_rvalid),
		.st_rready  (st_rready)
	);

endmodule // axi_write_checker

`default_nettype wire

// *** verif/axi_write_checker_sva.sv ***
/* Checker for flag timing, stickiness and the status port.
   Bound into axi_write_checker; one clock, mclk. */
`timescale 1ns/100ps
`default_nettype none
module axi_wchk_sva #(
	parameter logic [1:0] PROTOCOL = axi_wchk_pkg::MODE_AXI4,
	parameter int         ADDR_W   = 32
) (
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic              aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [1:0]        awburst,
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic              st_rvalid,
	input wire logic              st_rready,
	input wire logic [31:0]       st_rdata,
	input wire logic [1:0]        st_rresp,
	input wire logic [26:0]       violation_flags
);
	localparam bit FULL = PROTOCOL != axi_wchk_pkg::MODE_LITE;
	logic stall_q;
	// last edge saw a stalled offer; the link reset kills it
	always_ff @(posedge mclk, posedge rst)
		if (rst)
			stall_q <= 1'b0;
		else
			stall_q <= aresetn && awvalid && !awready;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_flags_sticky: assert property ($past(aresetn) |->
		(violation_flags & $past(violation_flags))
		== $past(violation_flags)) else $error("flag fell on live link");
	a_link_clear: assert property (!$past(aresetn) |->
		violation_flags == 27'h0) else $error("flags kept in link reset");
	a_dead_bits: assert property (violation_flags[3] == 1'b0 &&
		violation_flags[14] == 1'b0) else $error("unused flag raised");
	a_burst_rsvd: assert property (aresetn && awvalid && FULL &&
		awburst == axi_wchk_pkg::BURST_RSVD |=> violation_flags[2])
		else $error("reserved burst not flagged");
	a_addr_hold: assert property (aresetn && stall_q && awvalid &&
		awaddr != $past(awaddr) |=> violation_flags[9])
		else $error("address change not flagged");
	a_valid_drop: assert property (aresetn && stall_q && !awvalid
		|=> violation_flags[19]) else $error("valid drop not flagged");
	a_first_addr: assert property (aresetn && !$past(aresetn) &&
		awvalid |=> violation_flags[8]) else $error("early valid missed");
	a_status_stands: assert property (st_rvalid && !st_rready |=>
		st_rvalid && $stable(st_rdata)) else $error("answer not held");
	a_status_okay: assert property (st_rresp == 2'h0)
		else $error("status response not zero");
endmodule // axi_wchk_sva
bind axi_write_checker axi_wchk_sva #(.PROTOCOL(PROTOCOL), .ADDR_W(ADDR_W))
	chk (.mclk(mclk), .rst(rst), .aresetn(aresetn), .awaddr(awaddr),
	.awburst(awburst), .awvalid(awvalid), .awready(awready),
	.st_rvalid(st_rvalid), .st_rready(st_rready), .st_rdata(st_rdata),
	.st_rresp(st_rresp), .violation_flags(violation_flags));
`default_nettype wire

// *** verif/axi_wchk_pair.sv ***
/* Master and slave pair on the monitored write channels.
   Drives at the falling edge of mclk; the bench may override lines. */
`timescale 1ns/100ps
`default_nettype none
module axi_wchk_pair (
	input  wire logic       mclk,
	output var logic [3:0]  awid,
	output var logic [31:0] awaddr,
	output var logic [7:0]  awlen,
	output var logic [2:0]  awsize,
	output var logic [1:0]  awburst,
	output var logic [3:0]  awcache,
	output var logic [2:0]  awprot,
	output var logic [3:0]  awqos,
	output var logic [3:0]  awregion,
	output var logic        awvalid,
	output var logic        awready,
	output var logic [31:0] wdata,
	output var logic [3:0]  wstrb,
	output var logic        wlast,
	output var logic        wvalid,
	output var logic        wready
);
	// quiet link: nothing offered, slave ready at once
	initial begin
		{awid, awaddr, awlen, awprot, awqos, awregion, wdata} = '0;
		{awsize, awburst, awcache, wstrb, wlast} = 14'h27F;
		{awvalid, wvalid, awready, wready} = 4'h3;
	end
	// offer held until ready; slave may stall a few cycles first
	task automatic aw(input logic [31:0] a, input logic [7:0] l,
		input logic [2:0] s, input logic [1:0] b, input logic [3:0] c,
		input int stall);
		@(negedge mclk);
		{awaddr, awlen, awsize, awburst, awcache} = {a, l, s, b, c};
		awvalid = 1'b1;
		awready = (stall == 0);
		if (stall > 0) begin
			repeat (stall) @(negedge mclk);
			awready = 1'b1;
		end
		@(negedge mclk);
		awvalid = 1'b0;
		awaddr = ~awaddr; // released lines must not keep the old value
	endtask
	// one data beat, slave ready at once
	task automatic wb(input logic [3:0] s, input logic l);
		@(negedge mclk);
		{wstrb, wlast, wvalid} = {s, l, 1'b1};
		@(negedge mclk);
		wvalid = 1'b0;
		wdata = ~wdata;
	endtask
endmodule // axi_wchk_pair
`default_nettype wire

// *** verif/axi_write_channel_checker_test.sv ***
/* Bench for the write-channel checker: traffic from the pair model,
   flags compared after each case. Needs package, design, pair, checker. */
`timescale 1ns/100ps
`default_nettype none
module axi_write_channel_checker_test;
	logic             mclk = 1'b0;
	logic             rst = 1'b1;
	logic             aresetn = 1'b0;
	logic [9:0]       st_araddr = 10'h000;
	logic             st_arvalid = 1'b0;
	logic             st_rready = 1'b0;
	wire logic [3:0]  awid, awcache, awqos, awregion, wstrb;
	wire logic [31:0] awaddr, wdata, st_rdata;
	wire logic [7:0]  awlen;
	wire logic [2:0]  awsize, awprot;
	wire logic [1:0]  awburst, st_rresp;
	wire logic        awvalid, awready, wlast, wvalid, wready;
	wire logic        st_arready, st_rvalid;
	wire logic [26:0] violation_flags;
	int fails = 0;
	int checked = 0;
	typedef struct {
		logic [31:0] a;
		logic [7:0]  l;
		logic [2:0]  s;
		logic [1:0]  b;
		logic [3:0]  c;
		logic [26:0] f;
	} row_t;
	// one accepted address per row, then the flags it leaves
	row_t rows [11] = '{
		'{32'h00001000, 8'h03, 3'h2, 2'h1, 4'h3, 27'h0},
		'{32'h00000FFC, 8'h01, 3'h2, 2'h1, 4'h3, 27'h1},
		'{32'h00000FF8, 8'h01, 3'h2, 2'h1, 4'h3, 27'h0},
		'{32'h2, 8'h03, 3'h2, 2'h2, 4'h3, 27'h2},
		'{32'h0, 8'h00, 3'h2, 2'h3, 4'h3, 27'h4},
		'{32'h0, 8'h00, 3'h2, 2'h1, 4'h4, 27'h10},
		'{32'h0, 8'h00, 3'h2, 2'h1, 4'hE, 27'h0},
		'{32'h0, 8'h10, 3'h2, 2'h0, 4'h3, 27'h20},
		'{32'h0, 8'h0F, 3'h2, 2'h0, 4'h3, 27'h0},
		'{32'h0, 8'h02, 3'h2, 2'h2, 4'h3, 27'h40},
		'{32'h0, 8'h00, 3'h3, 2'h1, 4'h3, 27'h80}
	};
	always #20 mclk = ~mclk;
	axi_wchk_pair pair (.mclk(mclk), .awid(awid), .awaddr(awaddr),
		.awlen(awlen), .awsize(awsize), .awburst(awburst),
		.awcache(awcache), .awprot(awprot), .awqos(awqos),
		.awregion(awregion), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wlast(wlast), .wvalid(wvalid),
		.wready(wready));
	// short wait limit keeps the timeout case brief
	axi_write_checker #(.READY_WAIT_LIMIT(16'h0003)) DUT (.mclk(mclk),
		.rst(rst), .aresetn(aresetn), .awid(awid), .awaddr(awaddr),
		.awlen(awlen), .awsize(awsize), .awburst(awburst),
		.awcache(awcache), .awprot(awprot), .awqos(awqos),
		.awregion(awregion), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wlast(wlast), .wvalid(wvalid),
		.wready(wready), .st_araddr(st_araddr), .st_arvalid(st_arvalid),
		.st_arready(st_arready), .st_rdata(st_rdata),
		.st_rresp(st_rresp), .st_rvalid(st_rvalid),
		.st_rready(st_rready), .violation_flags(violation_flags));
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [39:0] seen,
		input logic [39:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic flags_are(input string what, input logic [26:0] exp);
		@(negedge mclk);
		cmp(what, 40'(violation_flags), 40'(exp));
		$display("done %s", what);
	endtask
	// pulse link reset; clean address fields, readies, strobes and last; valids and data untouched
	task automatic fresh;
		@(negedge mclk);
		aresetn = 1'b0;
		{pair.awid, pair.awaddr, pair.awlen, pair.awprot} = '0;
		{pair.awqos, pair.awregion, pair.awburst} = 10'h001;
		{pair.awsize, pair.awcache, pair.wlast} = 8'h47;
		{pair.awready, pair.wready, pair.wstrb} = 6'h3F;
		@(negedge mclk);
		aresetn = 1'b1;
	endtask
	// status read; the answer waits one cycle before it is taken
	task automatic st_read(input logic [9:0] a, input logic [31:0] exp);
		@(negedge mclk);
		{st_araddr, st_arvalid} = {a, 1'b1};
		@(negedge mclk);
		{st_araddr, st_arvalid} = {~a, 1'b0};
		@(negedge mclk);
		cmp("status", {st_rvalid, st_rresp, st_rdata}, {3'h4, exp});
		st_rready = 1'b1;
		@(negedge mclk);
		st_rready = 1'b0;
		cmp("status idle", {st_rvalid, st_arready}, 2'h1);
	endtask
	// a hang is cut short well past the expected run
	initial begin
		#100000;
		fails++;
		end_of_test();
	end
	initial begin
		repeat (16) @(negedge mclk);
		cmp("reset", {violation_flags, st_arready}, 28'h1);
		rst = 1'b0;
		foreach (rows[i]) begin
			fresh();
			pair.aw(rows[i].a, rows[i].l, rows[i].s, rows[i].b, rows[i].c, 0);
			repeat (2) @(negedge mclk);
			flags_are("row", rows[i].f);
		end
		// stalled offer while every address field moves
		fresh();
		@(negedge mclk);
		{pair.awready, pair.awvalid} = 2'h1;
		@(negedge mclk);
		{pair.awaddr, pair.awlen, pair.awsize} = {32'h4, 8'h1, 3'h1};
		{pair.awburst, pair.awcache, pair.awid} = 10'h021;
		{pair.awprot, pair.awqos, pair.awregion} = 11'h111;
		@(negedge mclk);
		pair.awready = 1'b1;
		@(negedge mclk);
		pair.awvalid = 1'b0;
		flags_are("addr hold", 27'h007BE00);
		// master drops valid after three stalls, one short of the warning
		fresh();
		@(negedge mclk);
		{pair.awready, pair.awvalid} = 2'h1;
		repeat (3) @(negedge mclk);
		{pair.awready, pair.awvalid} = 2'h2;
		flags_are("valid drop", 27'h0080000);
		fresh();
		pair.aw(32'h0, 8'h0, 3'h2, 2'h1, 4'h3, 4);
		flags_are("ready wait", 27'h0100000);
		// both valids up in the first live cycle
		fresh();
		@(negedge mclk);
		aresetn = 1'b0;
		@(negedge mclk);
		{aresetn, pair.awvalid, pair.wvalid} = 3'h7;
		@(negedge mclk);
		{pair.awvalid, pair.wvalid} = 2'h0;
		flags_are("first cycle", 27'h0800100);
		// stalled beat changes data, strobes and last marker
		fresh();
		pair.aw(32'h0, 8'h0, 3'h2, 2'h1, 4'h3, 0);
		{pair.wready, pair.wlast, pair.wvalid} = 3'h1;
		@(negedge mclk);
		{pair.wdata, pair.wstrb, pair.wlast} = {32'h5A5A5A5A, 4'h3, 1'b1};
		@(negedge mclk);
		pair.wready = 1'b1;
		@(negedge mclk);
		pair.wvalid = 1'b0;
		flags_are("data hold", 27'h7000000);
		// last marker on beat 0 of two, then last before its address
		fresh();
		pair.aw(32'h0, 8'h1, 3'h2, 2'h1, 4'h3, 0);
		pair.wb(4'hF, 1'b1);
		flags_are("early last", 27'h0200000);
		fresh();
		pair.wb(4'hF, 1'b1);
		pair.aw(32'h0, 8'h1, 3'h2, 2'h1, 4'h3, 0);
		flags_are("late addr", 27'h0200000);
		// byte beat at offset 2 strobing lane 0
		fresh();
		pair.aw(32'h2, 8'h1, 3'h0, 2'h1, 4'h3, 0);
		pair.wb(4'h1, 1'b0);
		flags_are("strobe lane", 27'h0400000);
		st_read(10'h000, 32'h00400000);
		st_read(10'h004, 32'h00000000);
		flags_are("sticky", 27'h0400000);
		end_of_test();
	end
endmodule // axi_write_channel_checker_test
`default_nettype wire
